// ### hdl/lan_port_pkg.sv
package lan_port_pkg;

  // ----------------------------------------------------------------
  // widths and mode bits
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int MODE_W = 3;
  localparam int MODE_BYTE_CTRL_STYLE_BIT = 0;
  localparam int MODE_ADDR_STROBE_STYLE_BIT = 1;
  localparam int MODE_BYTE_SWAP_EN_BIT = 2;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // byte mask codes {high lane, low lane}, active low
  // ----------------------------------------------------------------
  localparam logic [1:0] MASK_WORD = 2'h0;
  localparam logic [1:0] MASK_LOWER = 2'h2;
  localparam logic [1:0] MASK_UPPER = 2'h1;
  localparam logic [1:0] MASK_NONE = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic byte_op;
    logic fifo;
    logic [DATA_W-1:0] wdata;
  } dma_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] muxed_addr_data;
    logic bus_grant_in_n;
    logic ready_n;
    logic data_phase_strobe_n;
    logic read;
    logic cs_n;
    logic port_sel;
  } pins_in_t;

  localparam int PIN_IN_W = $bits(pins_in_t);

  typedef struct packed {
    logic [DATA_W-1:0] muxed_addr_data;
    logic [7:0] upper_address_lines;
    logic addr_strobe_pulse;
    logic byte_mask_low_lane;
    logic byte_mask_high_lane;
    logic xcvr_inbound_ctl_n;
    logic xcvr_outbound_ctl_n;
    logic data_phase_strobe_n;
    logic read;
    logic ready_n;
    logic hold_n;
  } pins_out_t;

  typedef struct packed {
    logic muxed_addr_data;
    logic upper_address_lines;
    logic addr_strobe_pulse;
    logic byte_mask_low_lane;
    logic byte_mask_high_lane;
    logic xcvr_inbound_ctl_n;
    logic xcvr_outbound_ctl_n;
    logic data_phase_strobe_n;
    logic read;
    logic ready_n;
    logic hold_n;
  } pins_oe_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_REQ = 3'h1,
    ST_ADDR_A = 3'h2,
    ST_ADDR_B = 3'h3,
    ST_DATA = 3'h4,
    ST_DONE = 3'h5
  } mst_state_t;

endpackage

// ### hdl/lane_steer.sv
module lane_steer
  import lan_port_pkg::*;
(
  // clock and reset, used by the checks only
  input wire logic i_clk,
  input wire logic i_reset_n,
  // mode
  input wire logic i_byte_ctrl_style,
  input wire logic i_byte_swap_en,
  // request
  input wire logic i_byte_op,
  input wire logic i_upper,
  input wire logic i_fifo,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [DATA_W-1:0] i_rbus,
  // encoded results
  output logic [1:0] o_mask,
  output logic o_byte_line,
  output logic o_addr_bit0,
  output logic [DATA_W-1:0] o_wbus,
  output logic [DATA_W-1:0] o_rdata
);
  logic swap;

  // ----------------------------------------------------------------
  // lane selection
  // ----------------------------------------------------------------
  // only fifo traffic swaps, descriptors stay in native order
  assign swap = i_byte_swap_en & i_fifo;
  assign o_mask = !i_byte_op ? MASK_WORD : (i_upper ? MASK_UPPER : MASK_LOWER);
  assign o_byte_line = i_byte_op;
  // word forces bit 0 low so the illegal code never leaves
  assign o_addr_bit0 = i_byte_op & (i_upper ^ swap);
  assign o_wbus = swap ? {i_wdata[7:0], i_wdata[15:8]} : i_wdata;
  assign o_rdata = swap ? {i_rbus[7:0], i_rbus[15:8]} : i_rbus;

  swap_lane_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    swap |-> (o_wbus[7:0] == i_wdata[15:8]) && (o_rdata[15:8] == i_rbus[7:0]))
    else $error("swapped word lost its high byte");
  byte_code_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_byte_ctrl_style && !i_byte_op) |-> !o_addr_bit0)
    else $error("word with address bit 0 high");
endmodule

// ### hdl/lan_bus_port.sv
module lan_bus_port
  import lan_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // mode load
  input wire logic i_mode_load,
  input wire logic [lan_port_pkg::MODE_W-1:0] i_mode,
  output logic [lan_port_pkg::MODE_W-1:0] o_mode,
  // dma request
  input wire logic i_dma_valid,
  input wire lan_port_pkg::dma_req_t i_dma_req,
  output logic o_dma_ready,
  output logic o_dma_done,
  output logic [lan_port_pkg::DATA_W-1:0] o_dma_rdata,
  // register access
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic o_reg_sel,
  output logic [lan_port_pkg::DATA_W-1:0] o_reg_wdata,
  input wire logic [lan_port_pkg::DATA_W-1:0] i_reg_rdata,
  // pins
  input wire lan_port_pkg::pins_in_t i_pins,
  output lan_port_pkg::pins_out_t o_pins,
  output lan_port_pkg::pins_oe_t o_pins_oe
);
  import lan_port_pkg::*;

  logic [MODE_W-1:0] mode_q;
  logic [PIN_IN_W-1:0] s1_q, s2_q, s3_q, filt_q;
  pins_in_t pin_f;
  mst_state_t st_q, st_d;
  dma_req_t req_q;
  logic master, addr_phase, mst_write;
  logic [DATA_W-1:0] ad_q, rdata_q, wbus, rdata_sw;
  logic [1:0] mask;
  logic byte_line, bit0, done_q;
  logic sl_act_q, sl_read_q, sl_sel_q, reg_wr_q, reg_rd_q;
  logic [DATA_W-1:0] reg_wdata_q;
  logic sl_start;

  // ----------------------------------------------------------------
  // mode bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= MODE_RESET;
    end else if (i_mode_load) begin
      mode_q <= i_mode;
    end
  end
  assign o_mode = mode_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a bit moves only when stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      filt_q <= '1;
    end else begin
      s1_q <= i_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
    end
  end
  assign pin_f = filt_q;

  // ----------------------------------------------------------------
  // master sequencer
  // ----------------------------------------------------------------
  // a new request waits for grant to be released first
  assign o_dma_ready = (st_q == ST_IDLE) && pin_f.bus_grant_in_n && !sl_act_q;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (i_dma_valid && o_dma_ready) begin
          st_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!pin_f.bus_grant_in_n) begin
          st_d = ST_ADDR_A;
        end
      end
      ST_ADDR_A: begin
        st_d = ST_ADDR_B;
      end
      ST_ADDR_B: begin
        st_d = ST_DATA;
      end
      ST_DATA: begin
        if (!pin_f.ready_n) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_q <= '0;
    end else if (i_dma_valid && o_dma_ready) begin
      req_q <= i_dma_req;
    end
  end

  assign master = (st_q == ST_ADDR_A) || (st_q == ST_ADDR_B) ||
                  (st_q == ST_DATA) || (st_q == ST_DONE);
  assign addr_phase = (st_q == ST_ADDR_A) || (st_q == ST_ADDR_B);
  assign mst_write = req_q.write;

  lane_steer lane_steer_i (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_byte_ctrl_style(mode_q[MODE_BYTE_CTRL_STYLE_BIT]),
    .i_byte_swap_en(mode_q[MODE_BYTE_SWAP_EN_BIT]),
    .i_byte_op(req_q.byte_op),
    .i_upper(req_q.addr[0]),
    .i_fifo(req_q.fifo),
    .i_wdata(req_q.wdata),
    .i_rbus(pin_f.muxed_addr_data),
    .o_mask(mask),
    .o_byte_line(byte_line),
    .o_addr_bit0(bit0),
    .o_wbus(wbus),
    .o_rdata(rdata_sw)
  );

  // ----------------------------------------------------------------
  // muxed line contents
  // ----------------------------------------------------------------
  // one register feeds the lines for both master and slave
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ad_q <= '0;
    end else if (st_q == ST_REQ && !pin_f.bus_grant_in_n) begin
      ad_q <= mode_q[MODE_BYTE_CTRL_STYLE_BIT] ? {req_q.addr[15:1], bit0} : req_q.addr[15:0];
    end else if (st_q == ST_ADDR_B) begin
      ad_q <= wbus;
    end else if (sl_start && pin_f.read) begin
      ad_q <= i_reg_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= (st_q == ST_DONE);
      if (st_q == ST_DATA && !pin_f.ready_n && !mst_write) begin
        rdata_q <= rdata_sw;
      end
    end
  end
  assign o_dma_done = done_q;
  assign o_dma_rdata = rdata_q;

  // ----------------------------------------------------------------
  // slave access
  // ----------------------------------------------------------------
  // grant low means we own the bus, so select then is not for us
  assign sl_start = !sl_act_q && !pin_f.cs_n && !pin_f.data_phase_strobe_n &&
                    pin_f.bus_grant_in_n && (st_q == ST_IDLE);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sl_act_q <= 1'b0;
      sl_read_q <= 1'b0;
      sl_sel_q <= 1'b0;
    end else if (sl_start) begin
      sl_act_q <= 1'b1;
      sl_read_q <= pin_f.read;
      sl_sel_q <= pin_f.port_sel;
    end else if (pin_f.data_phase_strobe_n) begin
      sl_act_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_wdata_q <= '0;
    end else begin
      reg_wr_q <= sl_start && !pin_f.read;
      reg_rd_q <= sl_start && pin_f.read;
      if (sl_start) begin
        reg_wdata_q <= pin_f.muxed_addr_data;
      end
    end
  end
  assign o_reg_wr = reg_wr_q;
  assign o_reg_rd = reg_rd_q;
  assign o_reg_sel = sl_sel_q;
  assign o_reg_wdata = reg_wdata_q;

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb begin
    o_pins = '1;
    o_pins_oe = '0;
    o_pins.muxed_addr_data = ad_q;
    o_pins.upper_address_lines = req_q.addr[23:16];
    o_pins_oe.upper_address_lines = master;
    o_pins_oe.muxed_addr_data = (master && (addr_phase || mst_write)) ||
                                (sl_act_q && sl_read_q);
    if (mode_q[MODE_ADDR_STROBE_STYLE_BIT]) begin
      o_pins.addr_strobe_pulse = (st_q != ST_ADDR_A);
    end else begin
      o_pins.addr_strobe_pulse = (st_q == ST_ADDR_A);
    end
    o_pins_oe.addr_strobe_pulse = master;
    // in byte control style pin 16 doubles as the grant chain and is then always driven, in mask style only while master
    if (mode_q[MODE_BYTE_CTRL_STYLE_BIT]) begin
      o_pins.byte_mask_low_lane = byte_line;
      o_pins.byte_mask_high_lane = !((st_q == ST_IDLE) && !pin_f.bus_grant_in_n);
      o_pins_oe.byte_mask_high_lane = 1'b1;
    end else begin
      o_pins.byte_mask_low_lane = mask[0];
      o_pins.byte_mask_high_lane = mask[1];
      o_pins_oe.byte_mask_high_lane = master;
    end
    o_pins_oe.byte_mask_low_lane = master;
    o_pins.xcvr_inbound_ctl_n = !(st_q == ST_DATA && !mst_write);
    o_pins.xcvr_outbound_ctl_n = !(mst_write || addr_phase);
    o_pins_oe.xcvr_inbound_ctl_n = master;
    o_pins_oe.xcvr_outbound_ctl_n = master;
    o_pins.data_phase_strobe_n = (st_q != ST_DATA);
    o_pins_oe.data_phase_strobe_n = master;
    o_pins.read = !mst_write;
    o_pins_oe.read = master;
    o_pins.ready_n = 1'b0;
    o_pins_oe.ready_n = sl_act_q;
    o_pins.hold_n = 1'b0;
    o_pins_oe.hold_n = (st_q != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  upper_release_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_IDLE || st_q == ST_REQ) |-> !o_pins_oe.upper_address_lines)
    else $error("upper address driven while not master");
  port_select_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    sl_start |=> o_reg_sel == $past(pin_f.port_sel))
    else $error("port select not taken at access start");
  ale_fall_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_ADDR_A && !mode_q[MODE_ADDR_STROBE_STYLE_BIT] && !i_mode_load) |->
    o_pins.addr_strobe_pulse ##1 !o_pins.addr_strobe_pulse ##1 !o_pins.addr_strobe_pulse)
    else $error("latch enable did not fall and stay low");
  as_pulse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_ADDR_A && mode_q[MODE_ADDR_STROBE_STYLE_BIT] && !i_mode_load) |->
    !o_pins.addr_strobe_pulse ##1 o_pins.addr_strobe_pulse)
    else $error("address strobe pulse wrong");
  word_mask_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (master && !mode_q[MODE_BYTE_CTRL_STYLE_BIT] && !req_q.byte_op) |->
    !o_pins.byte_mask_low_lane && !o_pins.byte_mask_high_lane)
    else $error("word access with a mask bit set");
  chain_grant_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode_q[MODE_BYTE_CTRL_STYLE_BIT] && st_q == ST_REQ) |-> o_pins.byte_mask_high_lane)
    else $error("grant passed on while requesting");
  inbound_ctl_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_DATA && !mst_write) |-> !o_pins.xcvr_inbound_ctl_n && o_pins.xcvr_outbound_ctl_n)
    else $error("transceiver control wrong in read data portion");
  outbound_ctl_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (master && mst_write) |-> !o_pins.xcvr_outbound_ctl_n && o_pins.xcvr_inbound_ctl_n)
    else $error("transceiver control wrong on write");
  das_phase_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_ADDR_B) |-> o_pins.data_phase_strobe_n ##1 !o_pins.data_phase_strobe_n)
    else $error("data strobe not low in data portion");
  bit0_word_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_ADDR_A && mode_q[MODE_BYTE_CTRL_STYLE_BIT] && !req_q.byte_op) |->
    !o_pins.muxed_addr_data[0])
    else $error("word with address bit 0 high");
  reset_mode_a: assert property (@(posedge i_clk)
    $rose(i_reset_n) |-> !mode_q[MODE_BYTE_CTRL_STYLE_BIT])
    else $error("byte control style set after reset");
endmodule

// ### test/mem_bus_model.sv
module mem_bus_model
  import lan_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // design pins
  input wire lan_port_pkg::pins_out_t i_out,
  input wire lan_port_pkg::pins_oe_t i_oe,
  // host side, driven by the bench
  input wire logic i_grant_other,
  input wire logic i_h_cs_n,
  input wire logic i_h_ds_n,
  input wire logic i_h_read,
  input wire logic i_h_sel,
  input wire logic i_h_drive,
  input wire logic [lan_port_pkg::DATA_W-1:0] i_h_data,
  input wire logic [lan_port_pkg::DATA_W-1:0] i_rdata,
  // resolved pins and captures
  output lan_port_pkg::pins_in_t o_pins,
  output logic [lan_port_pkg::DATA_W-1:0] o_bus,
  output logic [lan_port_pkg::ADDR_W-1:0] o_addr,
  output logic o_strobe,
  output logic [1:0] o_lanes,
  output logic [lan_port_pkg::DATA_W-1:0] o_wdata,
  output logic o_inb,
  output logic o_outb
);
  import lan_port_pkg::*;
  logic grant_n_q, ack_q, got_q, mst_ds, mst_rd;
  logic [DATA_W-1:0] last_q;
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  assign mst_ds = i_oe.data_phase_strobe_n && !i_out.data_phase_strobe_n;
  assign mst_rd = i_oe.read && i_out.read;
  // released bus shows inverse of last value, never a stale copy
  assign o_bus = i_oe.muxed_addr_data ? i_out.muxed_addr_data :
                 (ack_q && mst_rd) ? i_rdata : i_h_drive ? i_h_data : ~last_q;
  assign o_pins = '{muxed_addr_data: o_bus, bus_grant_in_n: grant_n_q,
                    ready_n: !(ack_q || i_oe.ready_n),
                    data_phase_strobe_n: i_oe.data_phase_strobe_n ?
                      i_out.data_phase_strobe_n : i_h_ds_n,
                    read: i_oe.read ? i_out.read : i_h_read,
                    cs_n: i_h_cs_n, port_sel: i_h_sel};
  // ----------------------------------------------------------------
  // arbiter and memory
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      grant_n_q <= 1'b1;
      ack_q <= 1'b0;
      got_q <= 1'b0;
      last_q <= '0;
    end else begin
      grant_n_q <= !(i_oe.hold_n || i_grant_other);
      ack_q <= mst_ds;
      last_q <= o_bus;
      got_q <= i_oe.addr_strobe_pulse && (got_q || i_out.data_phase_strobe_n);
      if (i_oe.addr_strobe_pulse && i_out.data_phase_strobe_n && !got_q) begin
        o_addr <= {i_out.upper_address_lines, o_bus};
        o_strobe <= i_out.addr_strobe_pulse;
        o_lanes <= {i_out.byte_mask_high_lane, i_out.byte_mask_low_lane};
      end
      if (mst_ds) begin
        o_wdata <= o_bus;
        o_inb <= i_out.xcvr_inbound_ctl_n;
        o_outb <= i_out.xcvr_outbound_ctl_n;
      end
    end
  end
endmodule

// ### test/lan_ctrl_parallel_bus_port_bench.sv
module lan_ctrl_parallel_bus_port_bench import lan_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
  logic i_clk, i_reset_n, mode_load, valid, grant_other, h_cs_n, h_ds_n, h_read, h_sel;
  logic h_drive, dma_ready, dma_done, reg_wr, reg_rd, reg_sel, cap_strobe, cap_inb, cap_outb;
  logic [MODE_W-1:0] mode, o_mode;
  logic [DATA_W-1:0] h_data, mem_rdata, reg_rdata, dma_rdata, reg_wdata, bus, cap_wdata;
  logic [ADDR_W-1:0] cap_addr;
  logic [1:0] cap_lanes;
  dma_req_t req;
  pins_in_t pins_in;
  pins_out_t pins_out;
  pins_oe_t pins_oe;
  int n_errors, checks, cycles;

  lan_bus_port lan_bus_port_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_mode_load(mode_load),
    .i_mode(mode), .o_mode(o_mode), .i_dma_valid(valid), .i_dma_req(req),
    .o_dma_ready(dma_ready), .o_dma_done(dma_done), .o_dma_rdata(dma_rdata),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_sel(reg_sel), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(reg_rdata), .i_pins(pins_in), .o_pins(pins_out), .o_pins_oe(pins_oe));
  mem_bus_model mem_bus_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_out(pins_out),
    .i_oe(pins_oe), .i_grant_other(grant_other), .i_h_cs_n(h_cs_n), .i_h_ds_n(h_ds_n),
    .i_h_read(h_read), .i_h_sel(h_sel), .i_h_drive(h_drive), .i_h_data(h_data),
    .i_rdata(mem_rdata), .o_pins(pins_in), .o_bus(bus), .o_addr(cap_addr),
    .o_strobe(cap_strobe), .o_lanes(cap_lanes), .o_wdata(cap_wdata), .o_inb(cap_inb),
    .o_outb(cap_outb));

  // ----------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // whole run needs well under 2000 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task do_reset();
    i_reset_n = 1'b0;
    repeat (16) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
  task set_mode(input logic [MODE_W-1:0] m);
    @(negedge i_clk);
    mode = m;
    mode_load = 1'b1;
    @(negedge i_clk);
    mode_load = 1'b0;
    `CHK(o_mode, m)
  endtask
  task dma(input logic [ADDR_W-1:0] a, input logic wr, bo, ff, input logic [DATA_W-1:0] wd);
    int k;
    @(negedge i_clk);
    req = '{addr: a, write: wr, byte_op: bo, fifo: ff, wdata: wd};
    valid = 1'b1;
    k = 0;
    while (dma_ready !== 1'b1 && k < 100) begin @(negedge i_clk); k++; end
    @(negedge i_clk);
    valid = 1'b0;
    k = 0;
    while (dma_done !== 1'b1 && k < 100) begin @(negedge i_clk); k++; end
    `CHK(k < 100, 1'b1)
    `CHK(pins_oe.upper_address_lines, 1'b0)
    `CHK(cap_addr[ADDR_W-1:1], a[ADDR_W-1:1])
    `CHK(cap_inb, wr)
    `CHK(cap_outb, !wr)
  endtask
  // host keeps select and port choice steady until the strobe returns
  task slave(input logic rd, sel, input logic [DATA_W-1:0] d);
    int k;
    @(negedge i_clk);
    reg_rdata = d;
    h_sel = sel;
    h_read = rd;
    h_data = d;
    h_drive = !rd;
    h_cs_n = 1'b0;
    h_ds_n = 1'b0;
    k = 0;
    while (reg_wr !== 1'b1 && reg_rd !== 1'b1 && k < 50) begin @(negedge i_clk); k++; end
    `CHK(reg_sel, sel)
    `CHK(rd ? reg_rd : reg_wr, 1'b1)
    if (!rd) `CHK(reg_wdata, d)
    k = 0;
    while (pins_in.ready_n !== 1'b0 && k < 50) begin @(negedge i_clk); k++; end
    if (rd) `CHK(bus, d)
    @(negedge i_clk);
    h_ds_n = 1'b1;
    h_cs_n = 1'b1;
    h_drive = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_reset();
    set_mode(3'h1);
    do_reset();
    `CHK(o_mode, MODE_RESET)
    `CHK(pins_oe, '0)
    $display("reset test done");
  endtask
  task test_mask_mode();
    logic [1:0] exp_lanes [3];
    logic [ADDR_W-1:0] addrs [3];
    exp_lanes = '{MASK_WORD, MASK_LOWER, MASK_UPPER};
    addrs = '{24'h5ac3e4, 24'h01f0a2, 24'h9e0017};
    set_mode(3'h0);
    for (int i = 0; i < 3; i++) begin
      dma(addrs[i], 1'b1, i != 0, 1'b0, 16'hc35a);
      `CHK(cap_lanes, exp_lanes[i])
      `CHK(cap_strobe, 1'b1)
      `CHK(cap_addr[0], addrs[i][0])
    end
    `CHK(cap_wdata, 16'hc35a)
    $display("mask mode test done");
  endtask
  task test_swap();
    mem_rdata = 16'h12ab;
    dma(24'h3c0100, 1'b0, 1'b0, 1'b0, 16'h0);
    `CHK(dma_rdata, 16'h12ab)
    set_mode(3'h4);
    dma(24'h3c0102, 1'b0, 1'b0, 1'b1, 16'h0);
    `CHK(dma_rdata, 16'hab12)
    dma(24'h3c0104, 1'b1, 1'b0, 1'b1, 16'h1234);
    `CHK(cap_wdata, 16'h3412)
    dma(24'h3c0106, 1'b1, 1'b0, 1'b0, 16'h1234);
    `CHK(cap_wdata, 16'h1234)
    dma(24'h3c0108, 1'b0, 1'b0, 1'b0, 16'h0);
    `CHK(dma_rdata, 16'h12ab)
    $display("swap test done");
  endtask
  task test_pulse_strobe();
    set_mode(3'h2);
    dma(24'h7700fe, 1'b1, 1'b0, 1'b0, 16'h0ff0);
    `CHK(cap_strobe, 1'b0)
    $display("pulse strobe test done");
  endtask
  // each row: mode, byte_op, addr bit0, fifo, expected bit0 (expected byte line is byte_op)
  task test_byte_line();
    logic [7:0] rows [6];
    rows = '{8'h13, 8'h10, 8'h15, 8'h5d, 8'h5e, 8'h5b};
    for (int i = 0; i < 6; i++) begin
      set_mode(rows[i][6:4]);
      dma({23'h2a1000, rows[i][2]}, 1'b1, rows[i][3], rows[i][1], 16'h55aa);
      `CHK(cap_lanes[0], rows[i][3])
      `CHK({cap_lanes[0], cap_addr[0]}, {rows[i][3], rows[i][3] & rows[i][0]})
      `CHK(cap_lanes[1], 1'b1)
    end
    $display("byte line test done");
  endtask
  task test_grant_chain();
    set_mode(3'h1);
    grant_other = 1'b1;
    repeat (10) @(negedge i_clk);
    `CHK(pins_out.byte_mask_high_lane, 1'b0)
    `CHK(pins_oe.byte_mask_high_lane, 1'b1)
    grant_other = 1'b0;
    repeat (10) @(negedge i_clk);
    $display("grant chain test done");
  endtask
  task test_slave();
    set_mode(3'h0);
    slave(1'b0, 1'b1, 16'h0f3c);
    slave(1'b1, 1'b0, 16'hbeef);
    slave(1'b0, 1'b0, 16'ha5c3);
    `CHK(pins_oe.upper_address_lines, 1'b0)
    $display("slave test done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {mode_load, valid, grant_other, h_drive, h_read, h_sel} = '0;
    {h_cs_n, h_ds_n} = 2'h3;
    mode = '0;
    req = '0;
    {h_data, mem_rdata, reg_rdata} = '0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    do_reset();
    test_reset();
    test_mask_mode();
    test_swap();
    test_pulse_strobe();
    test_byte_line();
    test_grant_chain();
    test_slave();
    end_of_test();
  end
endmodule
